// ### design/sync_trig_map.vh
`ifndef SYNC_TRIG_MAP_VH
`define SYNC_TRIG_MAP_VH
// APB register byte offsets.
`define REG_CTRL       8'h00
`define REG_START_IN   8'h04
`define REG_STOP_IN    8'h08
`define REG_START_OUT  8'h0c
`define REG_STOP_OUT   8'h10
`define REG_STATUS     8'h14
// Control register fields.
`define CTRL_ARM       0
`define CTRL_SW_START  1
`define CTRL_SW_STOP   2
// Action config fields: enable, line, polarity, once, skip first, skip factor, width.
`define ACT_EN         0
`define ACT_LINE_LO    1
`define ACT_LINE_HI    2
`define ACT_POL        3
`define ACT_ONCE       4
`define ACT_FIRST_LO   8
`define ACT_FIRST_HI   15
`define ACT_FACT_LO    16
`define ACT_FACT_HI    23
`define ACT_WID_LO     24
`define ACT_WID_HI     30
// Status fields.
`define STAT_ARMED     0
`define STAT_REC       1
`define STAT_PEND_ST   2
`define STAT_PEND_SP   3
// Timing: pulse width unit of 1 ms at 4 ns per cycle.
`define MS_NS          1000000
`define CLK_NS         4
`define MS_CYCLES      (`MS_NS / `CLK_NS)
`define MAX_WIDTH_MS   7'd99
`define CFG_RESET      32'h0000_0000
`endif

// ### design/sync_trigger_recording_control.v
// Functional notes
// (RULE1) Each input action detects rising or falling edges by its polarity bit.
// (RULE2) Accepted start takes effect at the next frame boundary strobe.
// (RULE3) Accepted stop ends recording when the current frame completes.
// (RULE4) Pulses on a line are alike; per-action counting picks the action.
// (RULE5) Start with skip factor 1, no skip first acts on pulses 1,3,5.
// (RULE6) Stop with skip first 1, skip factor 1 acts on pulses 2,4,6.
// (RULE7) Once armed, wait for a qualifying external start trigger.
// (RULE8) Output actions emit one pulse per commanded start or stop; the code emits none once the matching input action's single-shot flag is set.
// (RULE9) The far system must act on the output pulse as intended.
// (RULE10) Skip a configurable number of initial occurrences per action.
// (RULE11) After an effective trigger, skip a configurable number of occurrences.
// (RULE12) Single-shot actions act on the first qualifying event only.
// (RULE13) Output width up to 99 ms; zero holds the output asserted.
// (RULE14) Arming or config writes reset skip counters and single-shot flags.
// (RULE15) Trigger inputs pass a two-stage synchroniser before edge detection.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sync_trig_map.vh"
`default_nettype none
module sync_trigger_recording_control #(
	parameter        LINES     = 4,
	parameter [31:0] MS_CYC    = `MS_CYCLES
) (
	input  wire              mclk_in,
	input  wire              rst_n_in,
	input  wire              psel_in,
	input  wire              penable_in,
	input  wire              pwrite_in,
	input  wire [7:0]        paddr_in,
	input  wire [31:0]       pwdata_in,
	output reg  [31:0]       prdata_out,
	output reg               pready_out,
	output reg               pslverr_out,
	input  wire              frame_in,
	input  wire [LINES-1:0]  trig_in,
	output reg  [LINES-1:0]  trig_out,
	output reg               recording_out,
	output reg               armed_out
);
	reg  [31:0]      ctrl_ff;
	reg  [31:0]      cfg_ff [0:3];
	reg  [LINES-1:0] sync1_ff;
	reg  [LINES-1:0] sync2_ff;
	reg  [LINES-1:0] prev_ff;
	reg  [7:0]       cnt_ff [0:1];
	reg              done_ff [0:1];
	reg              pend_start_ff;
	reg              pend_stop_ff;
	reg  [6:0]       ms_left_ff [0:1];
	reg  [31:0]      tick_ff [0:1];
	reg  [1:0]       hold_ff;
	reg              armed_prev_ff;
	wire             wr_acc;
	wire             rd_acc;
	wire             cfg_wr;
	wire [1:0]       hit;
	wire             out_start;
	wire             out_stop;
	wire             mapped;
	wire [5:0]       sel;
	wire             restart;
	wire             nxt_recording;
	reg              cfg_wr_ff;
	integer          k;
	integer          j;

	localparam [6:0] MAX_WIDTH = `MAX_WIDTH_MS;

	// Register decode: one-hot select, zero for unmapped or unaligned offsets.
	function [5:0] reg_sel;
		input [7:0] addr;
		begin
			reg_sel = 6'h00;
			if (addr[1:0] == 2'b00) begin
				case (addr)
					`REG_CTRL:      reg_sel = 6'h01;
					`REG_START_IN:  reg_sel = 6'h02;
					`REG_STOP_IN:   reg_sel = 6'h04;
					`REG_START_OUT: reg_sel = 6'h08;
					`REG_STOP_OUT:  reg_sel = 6'h10;
					`REG_STATUS:    reg_sel = 6'h20;
					default:        reg_sel = 6'h00;
				endcase
			end
		end
	endfunction

	// Pulse width in whole milliseconds, limited to the longest legal pulse.
	function [6:0] clamp_width;
		input [31:0] cfg;
		begin
			if (cfg[`ACT_WID_HI:`ACT_WID_LO] > MAX_WIDTH) begin
				clamp_width = MAX_WIDTH;
			end else begin
				clamp_width = cfg[`ACT_WID_HI:`ACT_WID_LO];
			end
		end
	endfunction

	// Level of one output line from the two pulse generators.
	function line_level;
		input [1:0]  idx;
		input [1:0]  hold;
		input [31:0] cfg_a;
		input [31:0] cfg_b;
		begin
			line_level = (hold[0] && cfg_a[`ACT_LINE_HI:`ACT_LINE_LO] == idx && !cfg_a[`ACT_POL])
				|| (hold[1] && cfg_b[`ACT_LINE_HI:`ACT_LINE_LO] == idx && !cfg_b[`ACT_POL]);
		end
	endfunction

	assign wr_acc = psel_in & penable_in & pwrite_in;
	assign rd_acc = psel_in & ~penable_in & ~pwrite_in;
	assign sel    = reg_sel(paddr_in);
	assign mapped = |sel;
	assign cfg_wr = wr_acc & (|sel[4:1]);
	assign restart = cfg_wr_ff | (ctrl_ff[`CTRL_ARM] & ~armed_prev_ff);
	assign nxt_recording = frame_in ? ((recording_out | pend_start_ff) & ~pend_stop_ff)
		: recording_out;

	// Edge test of the selected line with a chosen polarity.
	function edge_hit;
		input [LINES-1:0] cur;
		input [LINES-1:0] prv;
		input [31:0]      cfg;
		reg   [1:0]       ln;
		begin
			ln = cfg[`ACT_LINE_HI:`ACT_LINE_LO];
			edge_hit = cfg[`ACT_EN] & (cfg[`ACT_POL] ? (~cur[ln] & prv[ln])
				: (cur[ln] & ~prv[ln]));
		end
	endfunction

	// APB slave: zero-wait, always ready in the access phase.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_ff     <= `CFG_RESET;
			prdata_out  <= 32'h0000_0000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			cfg_wr_ff   <= 1'b0;
			for (k = 0; k < 4; k = k + 1) begin
				cfg_ff[k] <= `CFG_RESET;
			end
		end else begin
			pready_out  <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~mapped;
			ctrl_ff[`CTRL_SW_START] <= 1'b0;
			ctrl_ff[`CTRL_SW_STOP]  <= 1'b0;
			cfg_wr_ff               <= cfg_wr;
			if (wr_acc && pready_out && mapped) begin
				case (paddr_in)
					`REG_CTRL: ctrl_ff <= {29'h0, pwdata_in[2:0]};
					`REG_START_IN: cfg_ff[0] <= pwdata_in;
					`REG_STOP_IN: cfg_ff[1] <= pwdata_in;
					`REG_START_OUT: cfg_ff[2] <= pwdata_in;
					`REG_STOP_OUT: cfg_ff[3] <= pwdata_in;
					default: ctrl_ff[`CTRL_ARM] <= ctrl_ff[`CTRL_ARM];
				endcase
			end
			if (rd_acc) begin
				case (paddr_in)
					`REG_CTRL: prdata_out <= {31'h0, ctrl_ff[`CTRL_ARM]};
					`REG_START_IN: prdata_out <= cfg_ff[0];
					`REG_STOP_IN: prdata_out <= cfg_ff[1];
					`REG_START_OUT: prdata_out <= cfg_ff[2];
					`REG_STOP_OUT: prdata_out <= cfg_ff[3];
					`REG_STATUS: prdata_out <= {28'h0, pend_stop_ff, pend_start_ff,
						recording_out, armed_out};
					default: prdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// (RULE15) Two-stage synchroniser.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= {LINES{1'b0}};
			sync2_ff <= {LINES{1'b0}};
			prev_ff  <= {LINES{1'b0}};
		end else begin
			sync1_ff <= trig_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// (RULE1) Polarity-selected edge detection.
	assign hit[0] = edge_hit(sync2_ff, prev_ff, cfg_ff[0]);
	assign hit[1] = edge_hit(sync2_ff, prev_ff, cfg_ff[1]);

	// Per-action pulse counting, one instance per input action.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_count
			wire act;
			// (RULE4) Count every pulse independently.
			assign act = hit[g] & ~done_ff[g] & (cnt_ff[g] == 8'h00);
			always @(posedge mclk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cnt_ff[g]   <= 8'h00;
					done_ff[g]  <= 1'b0;
				end else if (restart) begin
					// (RULE14) Restart counting.
					cnt_ff[g]   <= cfg_ff[g][`ACT_FIRST_HI:`ACT_FIRST_LO];
					done_ff[g]  <= 1'b0;
				end else if (hit[g] && !done_ff[g]) begin
					if (cnt_ff[g] != 8'h00) begin
						// (RULE10) Skip first occurrences.
						cnt_ff[g] <= cnt_ff[g] - 8'h01;
					end else begin
						// (RULE11) Reload interval skip count.
						cnt_ff[g]   <= cfg_ff[g][`ACT_FACT_HI:`ACT_FACT_LO];
						// (RULE12) Single shot latches done.
						done_ff[g]  <= cfg_ff[g][`ACT_ONCE];
					end
				end
			end
		end
	endgenerate

	// Recording state with frame alignment.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			armed_prev_ff <= 1'b0;
			armed_out     <= 1'b0;
			recording_out <= 1'b0;
			pend_start_ff <= 1'b0;
			pend_stop_ff  <= 1'b0;
		end else begin
			armed_prev_ff <= ctrl_ff[`CTRL_ARM];
			armed_out     <= ctrl_ff[`CTRL_ARM] & ~nxt_recording;
			// (RULE7) External start only while armed, software start even when disarmed; (RULE5) counting selects pulses.
			if (g_count[0].act && ctrl_ff[`CTRL_ARM] && !recording_out) begin
				pend_start_ff <= 1'b1;
			end else if (ctrl_ff[`CTRL_SW_START] && !recording_out) begin
				pend_start_ff <= 1'b1;
			end else if (frame_in) begin
				pend_start_ff <= 1'b0;
			end
			// (RULE6) Stop selection from its own counting.
			if ((g_count[1].act || ctrl_ff[`CTRL_SW_STOP]) && recording_out) begin
				pend_stop_ff <= 1'b1;
			end else if (frame_in) begin
				pend_stop_ff <= 1'b0;
			end
			if (frame_in) begin
				// (RULE2) Begin at frame boundary.
				if (pend_start_ff) begin
					recording_out <= 1'b1;
				end
				// (RULE3) End after the current frame.
				if (pend_stop_ff) begin
					recording_out <= 1'b0;
				end
			end
		end
	end

	// (RULE8) Output pulse on commanded start or stop, blocked while the matching input action's single-shot done flag is set.
	assign out_start = frame_in & pend_start_ff & ~pend_stop_ff;
	assign out_stop  = frame_in & pend_stop_ff;

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_out
			wire fire;
			assign fire = (g == 0) ? out_start : out_stop;
			always @(posedge mclk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					hold_ff[g]    <= 1'b0;
					ms_left_ff[g] <= 7'h00;
					tick_ff[g]    <= 32'h0000_0000;
				end else if (fire && cfg_ff[g+2][`ACT_EN] && !done_ff[g]) begin
					hold_ff[g]    <= 1'b1;
					// (RULE13) Width clamped at 99 ms, zero holds.
					ms_left_ff[g] <= clamp_width(cfg_ff[g+2]);
					tick_ff[g]    <= MS_CYC - 32'h0000_0001;
				end else if (hold_ff[g] && ms_left_ff[g] != 7'h00) begin
					if (tick_ff[g] == 32'h0000_0000) begin
						tick_ff[g]    <= MS_CYC - 32'h0000_0001;
						ms_left_ff[g] <= ms_left_ff[g] - 7'h01;
						hold_ff[g]    <= (ms_left_ff[g] != 7'h01);
					end else begin
						tick_ff[g] <= tick_ff[g] - 32'h0000_0001;
					end
				end
			end
		end
	endgenerate

	// Drive the configured output line high during its pulse; with the polarity bit set the line stays low.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trig_out <= {LINES{1'b0}};
		end else begin
			for (j = 0; j < LINES; j = j + 1) begin
				trig_out[j] <= line_level(j[1:0], hold_ff, cfg_ff[2], cfg_ff[3]);
			end
		end
	end
endmodule // sync_trigger_recording_control
`default_nettype wire

// ### dv/strc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module strc_chk #(
	parameter        LINES  = 4,
	parameter [31:0] MS_CYC = 32'd4
) (
	input wire             mclk_in,
	input wire             rst_n_in,
	input wire             psel_in,
	input wire             penable_in,
	input wire             pwrite_in,
	input wire [7:0]       paddr_in,
	input wire [31:0]      pwdata_in,
	input wire [31:0]      prdata_out,
	input wire             pready_out,
	input wire             pslverr_out,
	input wire             frame_in,
	input wire [LINES-1:0] trig_in,
	input wire [LINES-1:0] trig_out,
	input wire             recording_out,
	input wire             armed_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire setup = psel_in && !penable_in;
	wire bad_a = (paddr_in > 8'h14) || (paddr_in[1:0] != 2'h0);
	AST_RDY: assert property (setup |=> pready_out)
		else $error("No ready after setup.");
	AST_RDY_ONE: assert property (pready_out |-> penable_in ##1 !pready_out)
		else $error("Ready held too long.");
	AST_ERR: assert property (setup && bad_a |=> pslverr_out && pready_out)
		else $error("No error on bad address.");
	AST_NO_ERR: assert property (setup && !bad_a |=> !pslverr_out)
		else $error("Error on good address.");
	AST_ERR_RD: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
		else $error("Refused read not zero.");
	AST_START: assert property ($rose(recording_out) |-> $past(frame_in))
		else $error("Start off frame.");
	AST_STOP: assert property ($fell(recording_out) |-> $past(frame_in))
		else $error("Stop off frame.");
	AST_ARM: assert property (armed_out |-> !recording_out)
		else $error("Armed while recording.");
	cover property ($rose(recording_out));
	cover property ($fell(recording_out));
	cover property (pslverr_out);
	cover property ($rose(trig_out[LINES-1]));
endmodule // strc_chk
bind sync_trigger_recording_control strc_chk #(.LINES(LINES), .MS_CYC(MS_CYC)) strc_chk_i (.*);
`default_nettype wire

// ### dv/sync_trigger_recording_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sync_trigger_recording_control_tb;
	logic        mclk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0;
	logic        pwrite_in = 0, frame_in = 0, perr;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, rd;
	wire  [31:0] prdata_out;
	wire         pready_out, pslverr_out, recording_out, armed_out;
	wire  [3:0]  trig_in, trig_out;
	int          bad_count = 0, n_compared = 0;
	always #2 mclk_in = ~mclk_in;
	sync_trigger_recording_control #(.LINES(4), .MS_CYC(32'd4))
		sync_trigger_recording_control_i (.*);
	trig_peer trig_peer_i (.mclk_in(mclk_in), .out_in(trig_out), .line_out(trig_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		@(posedge mclk_in);
		while (pready_out !== 1'b1 && i < 20) begin
			@(posedge mclk_in);
			i++;
		end
		rd = prdata_out;
		perr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (i == 20) chk(0, 1);
	endtask
	task automatic frm;
		@(posedge mclk_in);
		frame_in <= 1'b1;
		@(posedge mclk_in);
		frame_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
	endtask
	task automatic pulse(input int k);
		trig_peer_i.hit(k, 1'b1);
		trig_peer_i.hit(k, 1'b0);
	endtask
	task automatic s_regs;
		apb(1'b1, 8'h04, 32'h0001_0001);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0001_0001);
		apb(1'b1, 8'h18, 32'hffff_ffff);
		chk(perr, 1);
		apb(1'b0, 8'h18, 32'h0);
		chk(perr, 1);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h06, 32'h0);
		chk(perr, 1);
	endtask
	task automatic s_line;
		logic [2:0] k;
		apb(1'b1, 8'h08, 32'h0001_0101);
		pulse(0);
		frm;
		chk(recording_out, 0);
		apb(1'b1, 8'h00, 32'h1);
		repeat (2) @(posedge mclk_in);
		chk(armed_out, 1);
		for (k = 3'h1; k <= 3'h4; k++) begin
			pulse(0);
			chk(recording_out, !k[0]);
			frm;
			chk(recording_out, k[0]);
		end
	endtask
	task automatic s_pol;
		apb(1'b1, 8'h04, 32'h0000_0019);
		apb(1'b1, 8'h08, 32'h0000_0003);
		trig_peer_i.hit(0, 1'b1);
		frm;
		chk(recording_out, 0);
		trig_peer_i.hit(0, 1'b0);
		frm;
		chk(recording_out, 1);
		pulse(1);
		frm;
		chk(recording_out, 0);
		pulse(0);
		frm;
		chk(recording_out, 0);
	endtask
	task automatic s_out;
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h0c, 32'h0200_0005);
		apb(1'b1, 8'h10, 32'h0000_0007);
		apb(1'b1, 8'h00, 32'h2);
		frm;
		chk(recording_out, 1);
		repeat (20) @(posedge mclk_in);
		chk(trig_peer_i.hi2, 8);
		chk(trig_peer_i.n_rise[2], 1);
		apb(1'b1, 8'h00, 32'h4);
		frm;
		chk(recording_out, 0);
		repeat (40) @(posedge mclk_in);
		chk(trig_out[3], 1);
		chk(trig_peer_i.n_rise[3], 1);
	endtask
	task automatic complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#40000;
		bad_count++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		chk({recording_out, armed_out, trig_out}, 32'h0);
		s_regs;
		s_line;
		s_pol;
		s_out;
		complete_run;
	end
endmodule // sync_trigger_recording_control_tb
`default_nettype wire

// ### dv/trig_peer.sv
`timescale 1ns/1ns
`default_nettype none
module trig_peer (
	input  wire        mclk_in,
	input  wire  [3:0] out_in,
	output logic [3:0] line_out
);
	logic [3:0]  prev_ff = 4'h0;
	int unsigned n_rise [4] = '{0, 0, 0, 0};
	int unsigned hi2 = 0;
	initial line_out = 4'h0;
	task automatic hit(input int k, input logic v);
		@(posedge mclk_in);
		line_out[k] <= v;
		repeat (6) @(posedge mclk_in);
	endtask
	always @(posedge mclk_in) begin
		prev_ff <= out_in;
		hi2 += out_in[2];
		for (int k = 0; k < 4; k++) begin
			if (out_in[k] && !prev_ff[k]) n_rise[k]++;
		end
	end
endmodule // trig_peer
`default_nettype wire
